/* File: core/pstx_core.sv */
// transmitter: pcm time-slot capture to codirectional dual-rail line output
`timescale 1ns/1ns
`default_nettype none
module pstx_core #(
   parameter int unsigned SYNC_STAGES = 2
) (
   // system
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   // pcm side
   input wire logic pcm_serial_in_i,
   input wire logic pcm_bit_clock_i,
   input wire logic slot_strobe_a_i,
   input wire logic slot_strobe_b_i,
   input wire logic slot_strobe_select_i,
   // line side
   input wire logic line_quarter_bit_clock_i,
   input wire logic violation_inhibit_alarm_i,
   output logic line_pos_n_o,
   output logic line_neg_n_o
);
   // two-stage synchronisers for all pins except serial data
   logic [5:0] sync1_q;
   logic [5:0] sync2_q;
   logic [5:0] pins;
   assign pins = {violation_inhibit_alarm_i, line_quarter_bit_clock_i, slot_strobe_select_i,
                  slot_strobe_b_i, slot_strobe_a_i, pcm_bit_clock_i};
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sync1_q <= 6'h00;
         sync2_q <= 6'h00;
      end else begin
         sync1_q <= pins;
         sync2_q <= sync1_q;
      end
   end
   // serial data needs one extra stage to line up with the bit clock path
   logic din1_q;
   logic din2_q;
   logic din3_q;
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         din1_q <= 1'b0;
         din2_q <= 1'b0;
         din3_q <= 1'b0;
      end else begin
         din1_q <= pcm_serial_in_i;
         din2_q <= din1_q;
         din3_q <= din2_q;
      end
   end

   // edge detection on synchronised clocks
   logic bclk_d1_q;
   logic qclk_d1_q;
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         bclk_d1_q <= 1'b0;
         qclk_d1_q <= 1'b0;
      end else begin
         bclk_d1_q <= sync2_q[0];
         qclk_d1_q <= sync2_q[4];
      end
   end
   wire bclk_rise = sync2_q[0] & ~bclk_d1_q;
   wire qclk_rise = sync2_q[4] & ~qclk_d1_q;
   wire alarm = sync2_q[5];
   // [RULE1] strobe select mux
   wire strobe_sel = sync2_q[3] ? sync2_q[1] : sync2_q[2];

   // input register: first sampled bit lands in bit 7
   logic [7:0] in_shift_q;
   logic [3:0] in_cnt_q;
   logic [7:0] in_shift_d;
   logic [3:0] in_cnt_d;
   // [RULE3] bits past the eighth refused until strobe drops
   wire sample = bclk_rise & strobe_sel & !in_cnt_q[3];
   // [RULE3] sample on bit clock rise in slot
   assign in_shift_d = sample ? {in_shift_q[6:0], din3_q} : in_shift_q;
   assign in_cnt_d = sample ? 4'(in_cnt_q + 4'h1) : (strobe_sel ? in_cnt_q : 4'h0);
   wire octet_done = sample & (in_cnt_q == 4'(pstx_pkg::OCTET_BITS - 1));
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         in_shift_q <= pstx_pkg::OCTET_RESET;
         in_cnt_q <= 4'h0;
      end else begin
         in_shift_q <= in_shift_d;
         in_cnt_q <= in_cnt_d;
      end
   end
   wire [7:0] captured = {in_shift_q[6:0], din3_q};

   // line timing: quarter and bit counters
   logic [1:0] qtr_q;
   logic [2:0] bit_q;
   logic run_q;
   wire block_end = qclk_rise & (qtr_q == pstx_pkg::LAST_QUARTER);
   wire word_end = block_end & (bit_q == pstx_pkg::LAST_BIT_IDX);
   wire need_load = qclk_rise & (!run_q | (word_end));

   // holding latch and repeat bookkeeping
   pstx_pkg::pstx_hold_e hold_q;
   pstx_pkg::pstx_hold_e hold_d;
   pstx_pkg::pstx_octet_s latch_q;
   logic [7:0] out_shift_q;
   logic [7:0] out_shift_d;
   logic run_d;
   logic load_ok;
   always_comb begin
      hold_d = hold_q;
      load_ok = 1'b0;
      if (need_load) begin
         case (hold_q)
            // [RULE14] repeat once then go idle
            pstx_pkg::PSTX_HOLD_NEW: begin
               load_ok = 1'b1;
               hold_d = pstx_pkg::PSTX_HOLD_OLD;
            end
            pstx_pkg::PSTX_HOLD_OLD: begin
               load_ok = 1'b1;
               hold_d = pstx_pkg::PSTX_HOLD_EMPTY;
            end
            pstx_pkg::PSTX_HOLD_EMPTY: hold_d = pstx_pkg::PSTX_HOLD_EMPTY;
            default: hold_d = pstx_pkg::PSTX_HOLD_EMPTY;
         endcase
      end
      // [RULE16] new capture overwrites; set wins over consumption
      if (octet_done) begin
         hold_d = pstx_pkg::PSTX_HOLD_NEW;
      end
   end
   // [RULE6] load shifter only at word end or from idle
   assign out_shift_d = (need_load & load_ok) ? latch_q.data :
                        (block_end ? {out_shift_q[6:0], 1'b0} : out_shift_q);
   // [RULE15] stop running when nothing left to send
   assign run_d = need_load ? load_ok : run_q;
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         hold_q <= pstx_pkg::PSTX_HOLD_EMPTY;
         latch_q <= '0;
      end else begin
         hold_q <= hold_d;
         // [RULE4] whole octet to holding latch
         if (octet_done) begin
            latch_q <= '{valid: 1'b1, data: captured};
         end
      end
   end

   // polarity: one rail per mark block; the violation repeats the previous rail
   logic cur_pos_q;
   // [RULE11] bits 7 and 8 share a polarity
   // [RULE17] violation on the final bit
   wire viol_now = (bit_q == pstx_pkg::VIOL_FIRST_IDX) & !alarm;
   // [RULE9] alternate the rail per block
   // [RULE12] alarm keeps strict alternation
   wire next_pos = (!need_load & viol_now) ? cur_pos_q : !cur_pos_q;
   wire pol_step = (need_load & load_ok) | (block_end & !word_end & run_q);
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         // [RULE19] defined start polarity
         cur_pos_q <= !pstx_pkg::INIT_POL_POS;
      end else if (pol_step) begin
         cur_pos_q <= next_pos;
      end
   end

   // shifter and run flag follow the holding latch
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         run_q <= 1'b0;
         out_shift_q <= pstx_pkg::OCTET_RESET;
      end else begin
         run_q <= run_d;
         out_shift_q <= out_shift_d;
      end
   end

   // quarter counter names the unit interval now on the line
   // [RULE7] four quarters per bit
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         qtr_q <= 2'h0;
      end else if (qclk_rise) begin
         qtr_q <= (need_load | !run_q) ? 2'h0 : 2'(qtr_q + 2'h1);
      end
   end

   // bit counter: position of the bit within the word
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         bit_q <= 3'h0;
      end else if (need_load) begin
         bit_q <= 3'h0;
      end else if (block_end) begin
         bit_q <= 3'(bit_q + 3'h1);
      end
   end

   // [RULE8] quarter pattern; [RULE18] msb first
   wire [3:0] pat = out_shift_q[7] ? pstx_pkg::PAT_ONE : pstx_pkg::PAT_ZERO;
   wire level = pat[2'h3 - qtr_q];
   // active-low rail: low only while running, on this rail, in an active quarter
   function automatic logic rail_n(input logic run, input logic on_rail, input logic lvl);
      rail_n = !(run & on_rail & !lvl);
   endfunction
   // [RULE5] outputs change only on quarter clock edges
   // [RULE10] active low rails, idle high
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         line_pos_n_o <= 1'b1;
         line_neg_n_o <= 1'b1;
      end else begin
         line_pos_n_o <= rail_n(run_q, cur_pos_q, level);
         line_neg_n_o <= rail_n(run_q, !cur_pos_q, level);
      end
   end

   // assertions
   // [RULE13] whole octets only: shifter loads at word end or from idle
   property p_load_at_boundary;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (need_load & load_ok) |-> (!run_q | bit_q == pstx_pkg::LAST_BIT_IDX);
   endproperty
   a_load_at_boundary: assert property (p_load_at_boundary) else $error("mid-word load"); // [RULE13]
   property p_idle_high;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      !run_q ##1 !run_q |-> line_pos_n_o & line_neg_n_o;
   endproperty
   a_idle_high: assert property (p_idle_high) else $error("line not idle"); // [RULE15]
   property p_capture_sets_new;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      octet_done |=> hold_q == pstx_pkg::PSTX_HOLD_NEW && latch_q.valid
                     && latch_q.data == $past(captured);
   endproperty
   a_capture_sets_new: assert property (p_capture_sets_new) else $error("capture lost"); // [RULE4]
   property p_repeat_once;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (need_load & hold_q == pstx_pkg::PSTX_HOLD_OLD & !octet_done)
      |=> hold_q == pstx_pkg::PSTX_HOLD_EMPTY;
   endproperty
   a_repeat_once: assert property (p_repeat_once) else $error("repeat not single"); // [RULE14]
   property p_one_rail;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      !(!line_pos_n_o & !line_neg_n_o);
   endproperty
   a_one_rail: assert property (p_one_rail) else $error("both rails active"); // [RULE9]
   property p_sample_count;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      sample |=> in_cnt_q == 4'($past(in_cnt_q) + 4'h1);
   endproperty
   a_sample_count: assert property (p_sample_count) else $error("bit count slip"); // [RULE3]
   property p_alarm_alternate;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (block_end & run_q & !word_end & alarm) |=> cur_pos_q != $past(cur_pos_q);
   endproperty
   a_alarm_alternate: assert property (p_alarm_alternate) else $error("no alternation"); // [RULE12]
   property p_violation;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (block_end & bit_q == pstx_pkg::VIOL_FIRST_IDX & !alarm) |=> cur_pos_q == $past(cur_pos_q);
   endproperty
   a_violation: assert property (p_violation) else $error("violation missing"); // [RULE11]

   // rails move only two cycles after a quarter clock rise
   property p_line_on_quarter;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      ($changed(line_pos_n_o) | $changed(line_neg_n_o)) |-> $past(qclk_rise, 2);
   endproperty
   a_line_on_quarter: assert property (p_line_on_quarter) else $error("line off quarter"); // [RULE5]

   // shifter takes the held octet and starts running
   property p_load_from_latch;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (need_load & load_ok) |=> run_q && latch_q.valid && out_shift_q == $past(latch_q.data);
   endproperty
   a_load_from_latch: assert property (p_load_from_latch) else $error("bad load"); // [RULE6]

   // nothing starts while the latch is empty
   property p_idle_until_capture;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (qclk_rise & !run_q & hold_q == pstx_pkg::PSTX_HOLD_EMPTY) |=> !run_q;
   endproperty
   a_idle_until_capture: assert property (p_idle_until_capture) else $error("start empty"); // [RULE15]

   // bit stays put for the inner quarters
   property p_shift_hold;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (qclk_rise & run_q & !block_end) |=> out_shift_q == $past(out_shift_q)
                                            && bit_q == $past(bit_q);
   endproperty
   a_shift_hold: assert property (p_shift_hold) else $error("bit cut short"); // [RULE7]

   // running stops only at a word boundary
   property p_run_stops_at_word;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (run_q & !run_d) |-> word_end;
   endproperty
   a_run_stops_at_word: assert property (p_run_stops_at_word) else $error("partial word"); // [RULE13]

   // coverage of the main scenarios
   c_octet: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i) octet_done);
   c_repeat: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
                             need_load & hold_q == pstx_pkg::PSTX_HOLD_OLD);
   c_overwrite: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
                                octet_done & hold_q == pstx_pkg::PSTX_HOLD_NEW);
   c_alarm_word: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
                                 word_end & alarm);
   c_idle_return: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
                                  need_load & run_q & !load_ok);
endmodule
`default_nettype wire

/* File: core/pstx_pkg.sv */
// package: constants, types and rule summary for the slot-to-line transmitter
// Behaviour
// [RULE1] slot select high picks strobe a, low picks strobe b
// [RULE2] outside party makes an eight-pulse strobe, rising on falling bit clock
// [RULE3] while strobe high, sample serial input on each bit clock rising edge, eight
// [RULE4] a complete captured octet moves into the holding latch
// [RULE5] line output timed only by the 256 kHz quarter-bit clock
// [RULE6] latch loads shifter only after previous eight coded bits are sent
// [RULE7] each data bit takes exactly four quarter-bit clock periods
// [RULE8] active low pattern: zero is 0101, one is 0011
// [RULE9] coded blocks alternate between positive and negative outputs
// [RULE10] both outputs active low, so line shows 1010 and 1100
// [RULE11] seventh and eighth bits go out on the same output
// [RULE12] alarm input high suppresses the violation, strict alternation kept
// [RULE13] slips repeat or delete whole octets only
// [RULE14] missing new octet: resend previous one, once per shortfall
// [RULE15] still nothing after the repeat: hold both outputs high
// [RULE16] new octet before transfer overwrites the held octet
// [RULE17] violation block marks the final bit of each word
// [RULE18] first sampled bit is sent first
// [RULE19] after reset outputs idle high with defined initial polarity
package pstx_pkg;
   localparam int unsigned OCTET_BITS = 8;
   localparam int unsigned QUARTERS_PER_BIT = 4;
   localparam logic [2:0] LAST_BIT_IDX = 3'h7;
   localparam logic [2:0] VIOL_FIRST_IDX = 3'h6;
   localparam logic [1:0] LAST_QUARTER = 2'h3;
   // active-low quarter patterns, first quarter in bit 3
   localparam logic [3:0] PAT_ZERO = 4'h5;
   localparam logic [3:0] PAT_ONE = 4'h3;
   localparam logic INIT_POL_POS = 1'b1;
   localparam logic [7:0] OCTET_RESET = 8'h00;

   // holding latch state
   typedef enum logic [1:0] {
      PSTX_HOLD_EMPTY = 2'b00, // nothing left to send, outputs idle once the current word ends
      PSTX_HOLD_NEW = 2'b01, // fresh octet waiting
      PSTX_HOLD_OLD = 2'b10 // last octet, may be repeated once
   } pstx_hold_e;

   // latched octet carrier
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } pstx_octet_s;
endpackage

/* File: testbench/pstx_pcm_model.sv */
// pcm bus model: bit clock, slot strobes, serial data
`timescale 1ns/1ns
`default_nettype none
module pstx_pcm_model (
   // system
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   // bench request
   input wire logic go_i,
   input wire logic [7:0] oct_i,
   input wire logic use_a_i,
   // pcm pins
   output logic bclk_o,
   output logic sa_o,
   output logic sb_o,
   output logic sd_o,
   output logic busy_o
);
   logic [3:0] div_q;
   logic [3:0] nb_q;
   logic [7:0] oct_q;
   logic pend_q;
   logic stb_q;
   logic a_q;
   logic more;
   // bit clock high five cycles, low five
   assign bclk_o = div_q < 4'h5;
   assign sa_o = stb_q & a_q;
   assign sb_o = stb_q & ~a_q;
   assign busy_o = pend_q | stb_q;
   assign more = busy_o && nb_q != 4'h8;
   // eight rises, edges on falling clock
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         div_q <= 4'h0;
         nb_q <= 4'h0;
         oct_q <= 8'h00;
         pend_q <= 1'b0;
         stb_q <= 1'b0;
         a_q <= 1'b1;
         sd_o <= 1'b0;
      end else begin
         div_q <= (div_q == 4'h9) ? 4'h0 : div_q + 4'h1;
         if (go_i && !busy_o) begin
            pend_q <= 1'b1;
            oct_q <= oct_i;
            a_q <= use_a_i;
         end
         if (div_q == 4'h4) begin
            // idle data toggles so nothing stale is read
            sd_o <= more ? oct_q[3'h7 - nb_q[2:0]] : ~sd_o;
            stb_q <= more;
            nb_q <= more ? nb_q + 4'h1 : 4'h0;
            if (busy_o) begin
               pend_q <= 1'b0;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// bench: pcm slots in, dual-rail line decoded and checked
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic clk_sys_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic lclk = 1'b0;
   logic sel = 1'b1;
   logic alarm = 1'b0;
   logic go = 1'b0;
   logic use_a = 1'b1;
   logic [7:0] oct = 8'h00;
   logic [7:0] b;
   logic [7:0] word;
   logic [3:0] pp;
   logic [3:0] nn;
   logic [3:0] pat;
   logic bclk, sa, sb, sd, busy, pos_n, neg_n, cur, prev;
   logic first = 1'b1;
   logic have = 1'b0;
   int qc = 0;
   int bc = 0;
   int w;
   int errors = 0;
   int samples_checked = 0;
   logic [7:0] exp_q[$];
   pstx_core u_pstx_core (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
      .pcm_serial_in_i(sd), .pcm_bit_clock_i(bclk), .slot_strobe_a_i(sa),
      .slot_strobe_b_i(sb), .slot_strobe_select_i(sel), .line_quarter_bit_clock_i(lclk),
      .violation_inhibit_alarm_i(alarm), .line_pos_n_o(pos_n), .line_neg_n_o(neg_n));
   pstx_pcm_model u_pstx_pcm_model (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
      .go_i(go), .oct_i(oct), .use_a_i(use_a), .bclk_o(bclk), .sa_o(sa), .sb_o(sb),
      .sd_o(sd), .busy_o(busy));
   initial forever #10 clk_sys_i = ~clk_sys_i;
   // line clock 160 ns, phase unrelated
   initial begin
      #7;
      forever #80 lclk = ~lclk;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic send(input logic [7:0] v, input logic a);
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 500) begin
         @(posedge clk_sys_i);
         n++;
      end
      check(8'(n < 500), 8'h01);
      if (n >= 500) wrap_up();
      oct <= v;
      use_a <= a;
      go <= 1'b1;
      @(posedge clk_sys_i);
      go <= 1'b0;
      @(posedge clk_sys_i);
   endtask
   task automatic drain(input string s);
      int n;
      n = 0;
      while ((exp_q.size() != 0 || bc != 0 || qc != 0) && n < 5000) begin
         @(posedge clk_sys_i);
         n++;
      end
      check(8'(n < 5000), 8'h01);
      if (n >= 5000) wrap_up();
      // quiet spell: any extra word is unexpected
      repeat (600) @(posedge clk_sys_i);
      $display("test %s done", s);
   endtask
   // quarters into blocks, blocks into words
   always @(posedge lclk) begin
      if (reset_n_i === 1'b1 && (qc != 0 || pos_n !== 1'b1 || neg_n !== 1'b1)) begin
         pp = {pp[2:0], pos_n};
         nn = {nn[2:0], neg_n};
         qc++;
         if (qc == 4) begin
            qc = 0;
            cur = nn === 4'hf;
            pat = cur ? pp : nn;
            check({4'h0, cur ? nn : pp}, 8'h0f);
            check(8'(pat === pstx_pkg::PAT_ONE || pat === pstx_pkg::PAT_ZERO), 8'h01);
            if (first) check(8'(cur), 8'(pstx_pkg::INIT_POL_POS));
            else if (have) check(8'(cur), 8'((bc == 7 && !alarm) ? prev : !prev));
            first = 1'b0;
            have = 1'b1;
            prev = cur;
            word = {word[6:0], pat === pstx_pkg::PAT_ONE};
            bc++;
            if (bc == 8) begin
               bc = 0;
               check(word, exp_q.size() != 0 ? exp_q.pop_front() : ~word);
            end
         end
      end else begin
         check(8'(bc), 8'h00);
         bc = 0;
         have = 1'b0;
      end
   end
   initial begin
      void'($urandom(32'h857809fc));
      repeat (6) @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      check({6'h00, pos_n, neg_n}, 8'h03);
      // both strobes, alarm off and on; sent, repeated once, then idle
      for (int i = 0; i < 4; i++) begin
         b = 8'($urandom());
         sel <= i[0];
         alarm <= i[1];
         exp_q.push_back(b);
         exp_q.push_back(b);
         send(b, i[0]);
         drain("strobe select, alarm, repeat");
      end
      sel <= 1'b0;
      send(8'($urandom()), 1'b1);
      drain("unselected strobe a");
      sel <= 1'b1;
      send(8'($urandom()), 1'b0);
      drain("unselected strobe");
      b = 8'($urandom());
      exp_q.push_back(b);
      send(b, 1'b1);
      w = 0;
      while (qc == 0 && bc == 0 && w < 1000) begin
         @(posedge clk_sys_i);
         w++;
      end
      check(8'(w < 1000), 8'h01);
      if (w >= 1000) wrap_up();
      b = 8'($urandom());
      exp_q.push_back(b);
      exp_q.push_back(b);
      send(8'($urandom()), 1'b1);
      send(b, 1'b1);
      drain("overwrite during word");
      wrap_up();
   end
endmodule
`default_nettype wire
